/* lbt_defs.svh */
// Register indexes, reset values, frame layout and pattern constants
`ifndef LBT_DEFS_SVH
`define LBT_DEFS_SVH
`define LBT_IDX_COUNT 8'h44
`define LBT_IDX_PATTERN 8'h45
`define LBT_IDX_CRC 8'h46
`define LBT_IDX_TMO 8'h47
`define LBT_IDX_GOOD 8'h48
`define LBT_IDX_STATUS 8'h4a
`define LBT_COUNT_RST 8'h07
`define LBT_PATTERN_RST 8'h00
`define LBT_COUNT_MAX 8'h64
`define LBT_CNT_FULL 8'hff
`define LBT_LEN_SHORT 11'h03c
`define LBT_LEN_LONG 11'h5ea
`define LBT_SA_FIRST 11'h006
`define LBT_TYPE_POS 11'h00c
`define LBT_TYPE_HI 8'h08
`define LBT_TYPE_LO 8'h00
`define LBT_WORD_55AA 16'h55aa
`define LBT_WORD_0F0F 16'h0f0f
`define LBT_WORD_FF00 16'hff00
`define LBT_FIFO_DEPTH 8
`endif

/* lbt_pkg.sv */
// Types shared by the loop back test packet generator
package lbt_pkg;
    typedef enum logic {LBT_IDLE, LBT_SEND} lbt_state_t;
endpackage : lbt_pkg

/* lbt_top.sv */
// Loop back test packet setup registers, frame builder and output FIFO
`timescale 1ns/10ps
`include "lbt_defs.svh"

module lbt_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] fill;
    logic push;
    logic pop;

    assign in_ready = (fill != (AW+1)'(DEPTH));
    assign out_valid = (fill != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            fill <= '0;
        end else begin
            if (push) begin
                wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : AW'(wr_ptr + 1'b1);
            end
            if (pop) begin
                rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : AW'(rd_ptr + 1'b1);
            end
            fill <= (AW+1)'(fill + {AW'(0), push} - {AW'(0), pop});
        end
    end
endmodule : lbt_fifo

// Operation
// - Writing zero to the count register clears transmit and receive frame counters.
// - On center side, zero write also clears CRC, timeout and good result counters.
// - On center side, count N from 1 to 100 sends exactly N packets.
// - Count register resets to seven; packets are sent only after a count is written.
// - Selector 0,1,2,4 give 55AA frames: 64/1518 unicast, 64/1518 broadcast.
// - Selector 08,10,20,40 give 0F0F frames: 64/1518 unicast, 64/1518 broadcast.
// - Selector 80 gives 1518-byte broadcast FF00 frames; other values are undefined.
// - First frame destination is base address with last byte plus one.
// - Each following frame increments the destination last byte by one.
// - Source is the base address unchanged; type/length field is 0x0800.
// - Center side result counters count CRC error, timeout and good returns.
module lbt_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic pready,
    output logic [31:0] prdata,
    output logic pslverr,
    input wire logic center_side,
    input wire logic [47:0] base_addr,
    input wire logic rx_crc_err,
    input wire logic rx_timeout,
    input wire logic rx_good,
    output logic clear_frame_counters,
    output logic [7:0] tx_data,
    output logic tx_last,
    output logic tx_valid,
    input wire logic tx_ready
);
    logic [7:0] loop_packet_count;
    logic [7:0] loop_pattern_select;
    logic [7:0] crc_count;
    logic [7:0] timeout_count;
    logic [7:0] good_count;
    lbt_pkg::lbt_state_t state;
    logic [7:0] remaining;
    logic [7:0] frame_idx;
    logic [10:0] byte_cnt;
    logic cur_long;
    logic cur_bcast;
    logic [15:0] cur_word;
    logic [7:0] reg_idx;
    logic mapped;
    logic wr_en;
    logic wr_count;
    logic zero_write;
    logic start_burst;
    logic fifo_in_ready;
    logic push;
    logic last_byte;
    logic [10:0] frame_len;
    logic [7:0] gen_byte;
    logic [2:0] addr_sel;
    logic [47:0] addr_shift;
    logic sel_long;
    logic sel_bcast;
    logic [15:0] sel_word;
    logic [31:0] next_prdata;

    assign reg_idx = paddr[9:2];
    assign mapped = (paddr[11:10] == 2'h0) && (paddr[1:0] == 2'h0) &&
        ((reg_idx >= `LBT_IDX_COUNT && reg_idx <= `LBT_IDX_GOOD) || reg_idx == `LBT_IDX_STATUS);
    assign wr_en = psel && penable && pready && pwrite && mapped;
    assign wr_count = wr_en && (reg_idx == `LBT_IDX_COUNT);
    assign zero_write = wr_count && (pwdata[7:0] == 8'h00);
    // Values above 100 are ignored for sending; they are stored only
    assign start_burst = wr_count && center_side && (pwdata[7:0] != 8'h00) &&
        (pwdata[7:0] <= `LBT_COUNT_MAX);

    // Undefined selector values fall back to the reset pattern
    always_comb begin
        unique case (loop_pattern_select)
            8'h01: {sel_long, sel_bcast, sel_word} = {1'b1, 1'b0, `LBT_WORD_55AA};
            8'h02: {sel_long, sel_bcast, sel_word} = {1'b0, 1'b1, `LBT_WORD_55AA};
            8'h04: {sel_long, sel_bcast, sel_word} = {1'b1, 1'b1, `LBT_WORD_55AA};
            8'h08: {sel_long, sel_bcast, sel_word} = {1'b0, 1'b0, `LBT_WORD_0F0F};
            8'h10: {sel_long, sel_bcast, sel_word} = {1'b1, 1'b0, `LBT_WORD_0F0F};
            8'h20: {sel_long, sel_bcast, sel_word} = {1'b0, 1'b1, `LBT_WORD_0F0F};
            8'h40: {sel_long, sel_bcast, sel_word} = {1'b1, 1'b1, `LBT_WORD_0F0F};
            8'h80: {sel_long, sel_bcast, sel_word} = {1'b1, 1'b1, `LBT_WORD_FF00};
            default: {sel_long, sel_bcast, sel_word} = {1'b0, 1'b0, `LBT_WORD_55AA};
        endcase
    end

    // APB: one wait state so read data comes from a flop
    always_comb begin
        next_prdata = 32'h0000_0000;
        unique case (reg_idx)
            `LBT_IDX_COUNT: next_prdata[7:0] = loop_packet_count;
            `LBT_IDX_PATTERN: next_prdata[7:0] = loop_pattern_select;
            `LBT_IDX_CRC: next_prdata[7:0] = crc_count;
            `LBT_IDX_TMO: next_prdata[7:0] = timeout_count;
            `LBT_IDX_GOOD: next_prdata[7:0] = good_count;
            `LBT_IDX_STATUS: next_prdata[8:0] = {state == lbt_pkg::LBT_SEND, remaining};
            default: next_prdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
            clear_frame_counters <= 1'b0;
        end else begin
            pready <= psel && penable && !pready;
            prdata <= (psel && penable && !pready && !pwrite) ? next_prdata : 32'h0000_0000;
            pslverr <= psel && penable && !pready && !mapped;
            clear_frame_counters <= zero_write;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loop_packet_count <= `LBT_COUNT_RST;
            loop_pattern_select <= `LBT_PATTERN_RST;
        end else if (wr_en) begin
            if (reg_idx == `LBT_IDX_COUNT) begin
                loop_packet_count <= pwdata[7:0];
            end
            if (reg_idx == `LBT_IDX_PATTERN) begin
                loop_pattern_select <= pwdata[7:0];
            end
        end
    end

    // Result counters saturate; an event in the clearing cycle still counts
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc_count <= 8'h00;
            timeout_count <= 8'h00;
            good_count <= 8'h00;
        end else if (zero_write && center_side) begin
            crc_count <= {7'h00, rx_crc_err};
            timeout_count <= {7'h00, rx_timeout};
            good_count <= {7'h00, rx_good};
        end else if (center_side) begin
            if (rx_crc_err && crc_count != `LBT_CNT_FULL) begin
                crc_count <= crc_count + 8'h01;
            end
            if (rx_timeout && timeout_count != `LBT_CNT_FULL) begin
                timeout_count <= timeout_count + 8'h01;
            end
            if (rx_good && good_count != `LBT_CNT_FULL) begin
                good_count <= good_count + 8'h01;
            end
        end
    end

    assign frame_len = cur_long ? `LBT_LEN_LONG : `LBT_LEN_SHORT;
    assign last_byte = (byte_cnt == 11'(frame_len - 11'h001));
    assign push = (state == lbt_pkg::LBT_SEND) && fifo_in_ready;
    assign addr_sel = (byte_cnt < `LBT_SA_FIRST) ? byte_cnt[2:0] : 3'(byte_cnt - `LBT_SA_FIRST);
    assign addr_shift = base_addr << {addr_sel, 3'b000};

    // Frame bytes; FCS is appended by the MAC downstream
    always_comb begin
        if (byte_cnt < `LBT_SA_FIRST && cur_bcast) begin
            gen_byte = 8'hff;
        end else if (byte_cnt == 11'h005) begin
            gen_byte = 8'(base_addr[7:0] + 8'h01 + frame_idx);
        end else if (byte_cnt < `LBT_TYPE_POS) begin
            gen_byte = addr_shift[47:40];
        end else if (byte_cnt < 11'(`LBT_TYPE_POS + 11'h002)) begin
            gen_byte = byte_cnt[0] ? `LBT_TYPE_LO : `LBT_TYPE_HI;
        end else begin
            gen_byte = byte_cnt[0] ? cur_word[7:0] : cur_word[15:8];
        end
    end

    // A new valid count restarts the burst, even mid-frame
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= lbt_pkg::LBT_IDLE;
            remaining <= 8'h00;
            frame_idx <= 8'h00;
            byte_cnt <= 11'h000;
            cur_long <= 1'b0;
            cur_bcast <= 1'b0;
            cur_word <= `LBT_WORD_55AA;
        end else if (start_burst) begin
            state <= lbt_pkg::LBT_SEND;
            remaining <= pwdata[7:0];
            frame_idx <= 8'h00;
            byte_cnt <= 11'h000;
            cur_long <= sel_long;
            cur_bcast <= sel_bcast;
            cur_word <= sel_word;
        end else if (push) begin
            if (last_byte) begin
                byte_cnt <= 11'h000;
                frame_idx <= frame_idx + 8'h01;
                remaining <= remaining - 8'h01;
                if (remaining == 8'h01) begin
                    state <= lbt_pkg::LBT_IDLE;
                end
            end else begin
                byte_cnt <= byte_cnt + 11'h001;
            end
        end
    end

    // Output stage keeps the stream outputs on flops; it refills in the cycle the sink takes a byte
    logic fifo_out_valid;
    logic fifo_out_ready;
    logic [8:0] fifo_out_data;
    assign fifo_out_ready = !tx_valid || tx_ready;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {tx_valid, tx_last, tx_data} <= 10'h000;
        end else if (fifo_out_ready) begin
            {tx_valid, tx_last, tx_data} <= {fifo_out_valid, fifo_out_data};
        end
    end
    lbt_fifo #(
        .WIDTH(9),
        .DEPTH(`LBT_FIFO_DEPTH)
    ) u_fifo (
        .clk(pclk),
        .rst_n(presetn),
        .in_valid(state == lbt_pkg::LBT_SEND),
        .in_ready(fifo_in_ready),
        .in_data({last_byte, gen_byte}),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready),
        .out_data(fifo_out_data)
    );

    logic count_written;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_written <= 1'b0;
        end else if (wr_count) begin
            count_written <= 1'b1;
        end
    end

    chk_count_default: assert property (@(posedge pclk) disable iff (!presetn)
        !count_written |-> loop_packet_count == 8'h07)
        else $error("count register lost its reset value");
    chk_clear_pulse: assert property (@(posedge pclk) disable iff (!presetn)
        zero_write |=> clear_frame_counters ##1 !clear_frame_counters)
        else $error("frame counter clear not pulsed");
    chk_result_clear: assert property (@(posedge pclk) disable iff (!presetn)
        zero_write && center_side && !rx_good && !rx_crc_err |=> good_count == 8'h00 && crc_count == 8'h00)
        else $error("result counters not cleared");
    chk_burst_start: assert property (@(posedge pclk) disable iff (!presetn)
        start_burst |=> state == lbt_pkg::LBT_SEND && remaining == $past(pwdata[7:0]) && byte_cnt == 11'h000)
        else $error("burst did not start");
    chk_burst_end: assert property (@(posedge pclk) disable iff (!presetn)
        push && last_byte && remaining == 8'h01 && !start_burst |=> state == lbt_pkg::LBT_IDLE)
        else $error("burst length wrong");
    chk_frame_len: assert property (@(posedge pclk) disable iff (!presetn)
        push && last_byte |-> byte_cnt == (cur_long ? 11'd1513 : 11'd59))
        else $error("frame length wrong");
    chk_da_first: assert property (@(posedge pclk) disable iff (!presetn)
        push && byte_cnt == 11'h005 && !cur_bcast && frame_idx == 8'h00 |-> gen_byte == 8'(base_addr[7:0] + 8'h01))
        else $error("first destination byte wrong");
    chk_da_step: assert property (@(posedge pclk) disable iff (!presetn)
        push && last_byte && remaining > 8'h01 && !start_burst |=> frame_idx == 8'($past(frame_idx) + 8'h01))
        else $error("destination step wrong");
    chk_type_field: assert property (@(posedge pclk) disable iff (!presetn)
        push && byte_cnt == 11'd12 && !start_burst |-> gen_byte == 8'h08 ##1 (!push || gen_byte == 8'h00))
        else $error("type field wrong");
    chk_bcast_da: assert property (@(posedge pclk) disable iff (!presetn)
        push && cur_bcast && byte_cnt < 11'd6 |-> gen_byte == 8'hff)
        else $error("broadcast destination wrong");
    chk_good_count: assert property (@(posedge pclk) disable iff (!presetn)
        center_side && rx_good && !zero_write && good_count != 8'hff |=> good_count == 8'($past(good_count) + 8'h01))
        else $error("good counter did not advance");

    cov_burst_done: cover property (@(posedge pclk) disable iff (!presetn)
        push && last_byte && remaining == 8'h01);
    cov_zero_write: cover property (@(posedge pclk) disable iff (!presetn) zero_write && center_side);
    cov_long_frame: cover property (@(posedge pclk) disable iff (!presetn) push && last_byte && cur_long);
    cov_fifo_full: cover property (@(posedge pclk) disable iff (!presetn)
        state == lbt_pkg::LBT_SEND && !fifo_in_ready);
endmodule : lbt_top

/* lbt_far_sink.sv */
// Far-side byte sink model that takes the test frame stream with stalls
`timescale 1ns/10ps

module lbt_far_sink (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] tx_data,
    input wire logic tx_last,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic hold
);
    logic [1:0] phase;
    logic [8:0] q[$];

    // Every fourth cycle refused, so the FIFO sees back-pressure during frames
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            phase <= 2'h0;
            tx_ready <= 1'b0;
        end else begin
            phase <= phase + 2'h1;
            tx_ready <= !hold && (phase != 2'h3);
        end
    end

    always @(posedge pclk) begin
        if (tx_valid && tx_ready) begin
            q.push_back({tx_last, tx_data});
        end
    end
endmodule : lbt_far_sink

/* tb_top.sv */
// Self-checking bench for the loop back test packet generator
`timescale 1ns/10ps
`include "lbt_defs.svh"

module tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic center_side = 1'b1;
    logic [2:0] rxp = 3'h0;
    logic hold = 1'b0;
    logic [47:0] base_addr = 48'h0212_3456_78f0;
    logic clear_frame_counters;
    logic [7:0] tx_data;
    logic tx_last;
    logic tx_valid;
    logic tx_ready;
    logic [31:0] rv;
    logic [31:0] ev;
    logic [7:0] sels[9] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h10, 8'h20, 8'h40, 8'h80};
    logic [31:0] exp_c[3] = '{32'h3, 32'h2, 32'h1};
    int miscompares = 0;
    int check_count = 0;

    always #2.5 pclk = ~pclk;

    lbt_top DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .center_side(center_side), .base_addr(base_addr), .rx_crc_err(rxp[0]), .rx_timeout(rxp[1]),
        .rx_good(rxp[2]), .clear_frame_counters(clear_frame_counters), .tx_data(tx_data),
        .tx_last(tx_last), .tx_valid(tx_valid), .tx_ready(tx_ready));

    lbt_far_sink u_sink (.pclk(pclk), .presetn(presetn), .tx_data(tx_data), .tx_last(tx_last),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .hold(hold));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task report_and_stop;
        $display("Comparisons %0d, mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    // Request held until the edge where pready is seen high
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Only the watchdog ends a wait for the answer
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = {31'h0, pslverr};
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task pulse(input logic [2:0] m, input int n);
        repeat (n) begin
            @(posedge pclk) rxp <= m;
            @(posedge pclk) rxp <= 3'h0;
        end
    endtask : pulse

    function int flen(input logic [7:0] sel);
        return (sel inside {8'h01, 8'h04, 8'h10, 8'h40, 8'h80}) ? int'(`LBT_LEN_LONG) : int'(`LBT_LEN_SHORT);
    endfunction : flen

    function logic [31:0] exp_byte(input logic [7:0] sel, input int f, input int i);
        logic bc;
        logic [15:0] w;
        logic [7:0] b;
        bc = sel inside {8'h02, 8'h04, 8'h20, 8'h40, 8'h80};
        w = (sel < 8'h08) ? `LBT_WORD_55AA : ((sel < 8'h80) ? `LBT_WORD_0F0F : `LBT_WORD_FF00);
        if (i < 6) begin
            b = bc ? 8'hff : ((i == 5) ? base_addr[7:0] + 8'h01 + 8'(f) : base_addr[47-8*i -: 8]);
        end else if (i < 12) begin
            b = base_addr[95-8*i -: 8];
        end else if (i < 14) begin
            b = (i == 12) ? 8'h08 : 8'h00;
        end else begin
            b = (i % 2 == 0) ? w[15:8] : w[7:0];
        end
        return {23'h0, i == flen(sel) - 1, b};
    endfunction : exp_byte

    // Sink held off first so the FIFO fills and refuses, then the frames drain
    task burst(input logic [7:0] sel, input logic [7:0] cnt);
        int n;
        int len;
        len = flen(sel);
        n = 0;
        u_sink.q.delete();
        hold <= 1'b1;
        apb(1'b1, 12'h114, {24'h0, sel});
        apb(1'b1, 12'h110, {24'h0, cnt});
        repeat (40) @(posedge pclk);
        check({31'h0, tx_valid}, 32'h1);
        check(32'(u_sink.q.size()), 32'h0);
        apb(1'b0, 12'h128, 32'h0);
        check({31'h0, rv[8]}, 32'h1);
        hold <= 1'b0;
        while (u_sink.q.size() < cnt * len && n < 40000) begin
            @(posedge pclk);
            n++;
        end
        repeat (8) @(posedge pclk);
        check(32'(u_sink.q.size()), 32'(cnt * len));
        for (int f = 0; f < cnt; f++) begin
            for (int i = 0; i < len; i++) begin
                check({23'h0, u_sink.q[f*len+i]}, exp_byte(sel, f, i));
            end
        end
        apb(1'b0, 12'h128, 32'h0);
        check(rv, 32'h0);
    endtask : burst

    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 12'h110, 32'h0);
        check(rv, 32'h07);
        apb(1'b0, 12'h114, 32'h0);
        check(rv, 32'h00);
        apb(1'b1, 12'h124, 32'h5);
        check(ev, 32'h1);
        pulse(3'h1, 3);
        pulse(3'h2, 2);
        pulse(3'h4, 1);
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 12'h118 + 12'(4 * k), 32'h0);
            check(rv, exp_c[k]);
        end
        apb(1'b1, 12'h110, 32'h0);
        @(posedge pclk);
        check({31'h0, clear_frame_counters}, 32'h1);
        @(posedge pclk);
        check({31'h0, clear_frame_counters}, 32'h0);
        for (int k = 0; k < 3; k++) begin
            apb(1'b0, 12'h118 + 12'(4 * k), 32'h0);
            check(rv, 32'h0);
        end
        pulse(3'h4, 260);
        apb(1'b0, 12'h120, 32'h0);
        check(rv, 32'hff);
        for (int k = 0; k < 9; k++) begin
            burst(sels[k], 8'h02);
        end
        // Top count and last address byte wrapping past 0xff
        burst(8'h00, 8'h64);
        // Outside the legal count range: stored but no frames
        u_sink.q.delete();
        apb(1'b1, 12'h110, 32'h65);
        repeat (20) @(posedge pclk);
        check(32'(u_sink.q.size()), 32'h0);
        center_side <= 1'b0;
        pulse(3'h1, 1);
        apb(1'b1, 12'h110, 32'h03);
        repeat (20) @(posedge pclk);
        check(32'(u_sink.q.size()), 32'h0);
        apb(1'b0, 12'h118, 32'h0);
        check(rv, 32'h0);
        apb(1'b1, 12'h110, 32'h0);
        @(posedge pclk);
        check({31'h0, clear_frame_counters}, 32'h1);
        // Terminal side zero write leaves the result counters alone
        apb(1'b0, 12'h120, 32'h0);
        check(rv, 32'hff);
        report_and_stop();
    end

    initial begin
        #400000;
        miscompares++;
        report_and_stop();
    end
endmodule : tb_top
